// ==== dv/charger_regs_monitor.sv ====
`timescale 1ns/100ps
module charger_regs_monitor
  import charger_regs_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic spi_clk, // Serial clock
  input wire logic spi_cs_n, // Select
  input wire logic spi_miso, // Data out
  input wire logic spi_miso_oe, // Drive on
  input wire logic regulator_ok_cmp, // Regulator
  input wire logic gated_dac_enable, // Dac on
  input wire logic auto_charge_enable, // Charge on
  input wire logic hardware_const_voltage_enable, // Cv on
  input wire logic pulse_charge_enable, // Pulse on
  input wire logic input_overvolt_detect_enable, // Ov on
  input wire logic [3:0] input_overvolt_threshold, // Code
  input wire millivolt_t overvolt_threshold_mv, // In mV
  input wire logic current_sense_compare_enable // Cs on
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  function automatic millivolt_t mv(input logic [3:0] c);
    if (c < 4'h9) return 14'(4200 + 50 * c);
    if (c < 4'hd) return 14'(6000 + 500 * (c - 4'h9));
    return 14'(8500 + 1000 * (c - 4'hd));
  endfunction
  sequence s_cs_idle;
    spi_cs_n [*2];
  endsequence
  sequence s_reg_low;
    !regulator_ok_cmp [*4];
  endsequence
  property p_thresh(lo, hi);
    $stable(input_overvolt_threshold) && input_overvolt_threshold inside {[lo:hi]}
      |-> overvolt_threshold_mv == mv(input_overvolt_threshold);
  endproperty
  a_dac_gate: assert property (gated_dac_enable |-> auto_charge_enable)
    else $error("dac on with master off");
  a_master_tie: assert property (auto_charge_enable == hardware_const_voltage_enable)
    else $error("charge enables differ");
  a_pulse_master: assert property (pulse_charge_enable |-> auto_charge_enable)
    else $error("pulse on with master off");
  a_pulse_reg_low: assert property (s_reg_low |-> !pulse_charge_enable)
    else $error("pulse on with regulator bad");
  a_miso_release: assert property (s_cs_idle |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_miso_timing: assert property ($changed(spi_miso) && $past(spi_miso_oe) |-> !$past(spi_clk))
    else $error("miso moved in clock high phase");
  a_write_only: assert property ($changed(input_overvolt_threshold) ||
      $changed(current_sense_compare_enable) || $changed(input_overvolt_detect_enable)
      |-> $past(spi_clk) && !$past(spi_cs_n))
    else $error("control changed outside a write");
  a_reset_values: assert property ($rose(nrst) |-> input_overvolt_detect_enable &&
      input_overvolt_threshold == 4'hf && !auto_charge_enable)
    else $error("bad value after reset");
  a_thresh_low: assert property (p_thresh(4'h0, 4'h8))
    else $error("low range threshold wrong");
  a_thresh_mid: assert property (p_thresh(4'h9, 4'hc))
    else $error("mid range threshold wrong");
  a_thresh_high: assert property (p_thresh(4'hd, 4'hf))
    else $error("high range threshold wrong");
endmodule
bind charger_control_status_regs charger_regs_monitor i_charger_regs_monitor (
  .sys_clk, .nrst, .spi_clk, .spi_cs_n, .spi_miso, .spi_miso_oe, .regulator_ok_cmp,
  .gated_dac_enable, .auto_charge_enable, .hardware_const_voltage_enable,
  .pulse_charge_enable, .input_overvolt_detect_enable, .input_overvolt_threshold,
  .overvolt_threshold_mv, .current_sense_compare_enable
);

// ==== dv/spi_host_model.sv ====
`timescale 1ns/100ps
module spi_host_model (
  input wire logic sys_clk, // Clock
  output logic spi_clk, // Serial clock
  output logic spi_cs_n, // Select
  output logic spi_mosi, // Data to device
  input wire logic spi_miso // Data from device
);
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Phases of 3 cycles keep clear of the 2-cycle minimum
  task automatic xfer(input logic [31:0] frame, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = frame[31-i];
      wt(3);
      if (i >= 16) rd[31-i] = spi_miso;
      spi_clk = 1'b1;
      wt(3);
      spi_clk = 1'b0;
    end
    wt(3);
    spi_cs_n = 1'b1;
    // Pulled down when released
    spi_mosi = 1'b0;
    wt(3);
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
  import charger_regs_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic overvolt_cmp = 1'b0;
  logic charger_present_cmp = 1'b0;
  logic regulator_ok_cmp = 1'b0;
  logic battery_cc_cmp = 1'b0;
  logic battery_cv_cmp = 1'b0;
  logic current_sense_cmp = 1'b0;
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic gated_dac_enable, auto_charge_enable, hardware_const_voltage_enable;
  logic pulse_charge_enable, input_overvolt_detect_enable, current_sense_compare_enable;
  logic [3:0] input_overvolt_threshold;
  millivolt_t overvolt_threshold_mv;
  logic [15:0] rd;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // Address, write data, read-back
  logic [46:0] rows [8] = '{
    {15'h0000, 16'hffff, 16'h0019}, {15'h0000, 16'h0000, 16'h0000},
    {15'h0002, 16'hffff, 16'h00f2}, {15'h0002, 16'h0000, 16'h0002},
    {15'h0004, 16'hffff, 16'h000c}, {15'h0004, 16'h0000, 16'h0004},
    {15'h0006, 16'hffff, 16'h0000}, {15'h7ffe, 16'hffff, 16'h0000}
  };
  logic [15:0] rst_val [3] = '{16'h0001, 16'h00f2, 16'h0004};
  wire [3:0] drv = {gated_dac_enable, auto_charge_enable, hardware_const_voltage_enable,
    pulse_charge_enable};
  charger_control_status_regs #(.DEBOUNCE_CYC(2)) i_charger_control_status_regs (
    .sys_clk, .nrst, .spi_clk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
    .overvolt_cmp, .charger_present_cmp, .regulator_ok_cmp, .battery_cc_cmp,
    .battery_cv_cmp, .current_sense_cmp, .gated_dac_enable, .auto_charge_enable,
    .hardware_const_voltage_enable, .pulse_charge_enable, .input_overvolt_detect_enable,
    .input_overvolt_threshold, .overvolt_threshold_mv, .current_sense_compare_enable
  );
  spi_host_model i_spi_host_model (.sys_clk, .spi_clk, .spi_cs_n, .spi_mosi, .spi_miso);
  always #50 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    i_spi_host_model.wt(n);
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    i_spi_host_model.xfer({1'b1, a, d}, 32, rd);
  endtask
  task automatic rg(input logic [14:0] a);
    i_spi_host_model.xfer({1'b0, a, 16'h0000}, 32, rd);
  endtask
  function automatic logic [15:0] exp_mv(input int c);
    if (c < 9) return 16'(4200 + 50 * c);
    if (c < 13) return 16'(6000 + 500 * (c - 9));
    return 16'(8500 + 1000 * (c - 13));
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is near 10400 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    tick(4);
    check(16'({input_overvolt_detect_enable, input_overvolt_threshold}), 16'h001f);
    nrst = 1'b1;
    tick(2);
    for (int i = 0; i < 3; i++) begin
      rg(15'(2 * i));
      check(rd, rst_val[i]);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][46:32], rows[i][31:16]);
      rg(rows[i][46:32]);
      check(rd, rows[i][15:0]);
    end
    $display("table test done");
    for (int c = 0; c < 16; c++) begin
      wr(15'h0002, 16'(c << 4));
      check(16'(input_overvolt_threshold), 16'(c));
      check(16'(overvolt_threshold_mv), exp_mv(c));
    end
    $display("threshold test done");
    wr(15'h0000, 16'h0008);
    check(16'(drv), 16'h0000);
    wr(15'h0000, 16'h0018);
    check(16'(drv), 16'h000e);
    regulator_ok_cmp = 1'b1;
    tick(4);
    check(16'(drv), 16'h000f);
    rg(15'h0000);
    check(rd, 16'h001a);
    wr(15'h0000, 16'h0010);
    check(16'(drv), 16'h0007);
    wr(15'h0000, 16'h0000);
    check(16'(drv), 16'h0000);
    $display("gating test done");
    charger_present_cmp = 1'b1;
    battery_cc_cmp = 1'b1;
    current_sense_cmp = 1'b1;
    rg(15'h0000);
    check(rd, 16'h0022);
    rg(15'h0004);
    check(rd, 16'h00a4);
    battery_cc_cmp = 1'b0;
    battery_cv_cmp = 1'b1;
    current_sense_cmp = 1'b0;
    rg(15'h0004);
    check(rd, 16'h0044);
    $display("status test done");
    wr(15'h0000, 16'h0001);
    overvolt_cmp = 1'b1;
    tick(1);
    overvolt_cmp = 1'b0;
    rg(15'h0000);
    check(rd, 16'h0023);
    overvolt_cmp = 1'b1;
    rg(15'h0000);
    check(rd, 16'h00a3);
    wr(15'h0000, 16'h0000);
    rg(15'h0000);
    check(rd, 16'h0022);
    $display("overvolt test done");
    i_spi_host_model.xfer({1'b1, 15'h0004, 16'h0008}, 20, rd);
    rg(15'h0004);
    check(rd, 16'h0044);
    check(16'(current_sense_compare_enable), 16'h0000);
    $display("abort test done");
    overvolt_cmp = 1'b0;
    charger_present_cmp = 1'b0;
    regulator_ok_cmp = 1'b0;
    battery_cv_cmp = 1'b0;
    wr(15'h0002, 16'h0030);
    nrst = 1'b0;
    tick(4);
    nrst = 1'b1;
    tick(2);
    rg(15'h0000);
    check(rd, 16'h0001);
    rg(15'h0002);
    check(rd, 16'h00f2);
    $display("second reset test done");
    close_out;
  end
endmodule

// ==== hw/charger_control_status_regs.sv ====
`timescale 1ns/100ps
`include "charger_regs_defines.svh"
// Notes on behaviour
// R1 - Master enable gates dac, auto charge, cv
// R2 - Word 0 bit 7 debounced input overvoltage
// R3 - Word 0 bit 5 shows charger present
// R4 - Word 0 bit 3 enables sense dac
// R5 - Word 0 bit 1 regulator ok; gates pulse
// R6 - Word 0 resets to 0001
// R7 - Threshold codes 0-8 step 50 mV
// R8 - Threshold codes 9-12 step 500 mV
// R9 - Threshold codes 13-15 step 1000 mV
// R10 - Word 1 resets to 00f2
// R11 - Word 2 bit 7 battery cc level
// R12 - Word 2 bit 6 battery cv level
// R13 - Word 2 bit 5 current sense level
// R14 - Word 2 bit 3 enables sense comparator
// R15 - Word 2 resets to 0004
// R16 - Frame: direction, 15 address, 16 data, msb first
// R17 - Read-only and unused bits ignore writes; unused bits read zero
// R18 - Status inputs synchronised before being read
module charger_control_status_regs
  import charger_regs_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `OVERVOLT_DEBOUNCE_CYC
) (
  input wire logic sys_clk, // 10 MHz system clock
  input wire logic nrst, // Async reset, active low
  input wire logic spi_clk, // Serial clock from master
  input wire logic spi_cs_n, // Chip select, active low
  input wire logic spi_mosi, // Serial data in
  output logic spi_miso, // Serial data out
  output logic spi_miso_oe, // Drive enable for serial data out
  input wire logic overvolt_cmp, // Input above overvoltage threshold
  input wire logic charger_present_cmp, // Valid charger seen
  input wire logic regulator_ok_cmp, // Charger regulator valid
  input wire logic battery_cc_cmp, // Battery above cc level
  input wire logic battery_cv_cmp, // Battery above cv level
  input wire logic current_sense_cmp, // Sense voltage above threshold
  output logic gated_dac_enable, // Sense dac on, after master gate
  output logic auto_charge_enable, // Automatic charge control on
  output logic hardware_const_voltage_enable, // Hardware cv loop on
  output logic pulse_charge_enable, // Pulse charge allowed
  output logic input_overvolt_detect_enable, // Overvoltage comparator on
  output logic [3:0] input_overvolt_threshold, // Threshold code
  output millivolt_t overvolt_threshold_mv, // Threshold in millivolts
  output logic current_sense_compare_enable // Sense comparator on
);

  // Stored control bits
  logic charger_master_enable_r;
  logic sense_dac_enable_r;
  logic overvolt_detect_enable_r;
  logic [3:0] threshold_r;
  logic cs_compare_enable_r;

  // Status path
  logic [5:0] status_raw;
  logic [5:0] status_sync;
  logic overvolt_sync;
  logic charger_present_sync;
  logic regulator_ok_sync;
  logic battery_cc_sync;
  logic battery_cv_sync;
  logic current_sense_sync;
  logic input_overvolt_flag_r;
  logic [15:0] debounce_cnt_r;

  // Serial port
  spi_state_t state_r;
  spi_state_t state_nxt;
  logic spi_clk_prev_r;
  logic clk_rise;
  logic clk_fall;
  logic [4:0] bit_cnt_r;
  logic [15:0] head_r;
  logic [15:0] wdata_r;
  logic [15:0] wdata_full;
  logic [15:0] rd_shift_r;
  logic write_dir;
  logic [14:0] frame_addr;
  logic commit_write;
  logic spi_miso_r;
  logic spi_miso_oe_r;

  // Output flops
  logic gated_dac_enable_r;
  logic auto_charge_enable_r;
  logic hw_cv_enable_r;
  logic pulse_charge_enable_r;
  millivolt_t threshold_mv_r;

  // Threshold code to millivolts over three ranges
  function automatic millivolt_t threshold_to_mv(input logic [3:0] code);
    millivolt_t step;
    step = 14'({10'd0, code});
    if (code <= `THRESH_LOW_LAST) begin
      threshold_to_mv = `THRESH_LOW_BASE_MV + step * `THRESH_LOW_STEP_MV; // [R7]
    end else if (code <= `THRESH_MID_LAST) begin
      step = 14'({10'd0, code - `THRESH_MID_FIRST});
      threshold_to_mv = `THRESH_MID_BASE_MV + step * `THRESH_MID_STEP_MV; // [R8]
    end else begin
      step = 14'({10'd0, code - `THRESH_HIGH_FIRST});
      threshold_to_mv = `THRESH_HIGH_BASE_MV + step * `THRESH_HIGH_STEP_MV; // [R9]
    end
  endfunction

  // Assembles the readable value of each register
  function automatic reg_word_t read_word(input logic [14:0] addr);
    reg_word_t w;
    w = 16'h0000;
    case (addr)
      `ADDR_CTRL_STATUS_0: begin
        w[`BIT_OVERVOLT_FLAG] = input_overvolt_flag_r; // [R2]
        w[`BIT_CHARGER_PRESENT] = charger_present_sync; // [R3]
        w[`BIT_MASTER_ENABLE] = charger_master_enable_r;
        w[`BIT_SENSE_DAC_ENABLE] = sense_dac_enable_r;
        w[`BIT_REGULATOR_OK] = regulator_ok_sync; // [R5]
        w[`BIT_OVERVOLT_DETECT_EN] = overvolt_detect_enable_r;
      end
      `ADDR_INPUT_THRESHOLD: begin
        w = `FIXED_INPUT_THRESHOLD;
        w[`THRESH_MSB:`THRESH_LSB] = threshold_r;
      end
      `ADDR_BATTERY_SENSE: begin
        w = `FIXED_BATTERY_SENSE;
        w[`BIT_BATTERY_CC] = battery_cc_sync; // [R11]
        w[`BIT_BATTERY_CV] = battery_cv_sync; // [R12]
        w[`BIT_CURRENT_SENSE] = current_sense_sync; // [R13]
        w[`BIT_CS_COMPARE_EN] = cs_compare_enable_r;
      end
      default: w = 16'h0000; // [R17]
    endcase
    read_word = w;
  endfunction

  // Comparator levels cross into the clock domain here
  assign status_raw = {current_sense_cmp, battery_cv_cmp, battery_cc_cmp,
                       regulator_ok_cmp, charger_present_cmp, overvolt_cmp};

  status_sync #(
    .WIDTH(6)
  ) u_status_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(status_raw),
    .sync_out(status_sync) // [R18]
  );

  assign overvolt_sync = status_sync[0];
  assign charger_present_sync = status_sync[1];
  assign regulator_ok_sync = status_sync[2];
  assign battery_cc_sync = status_sync[3];
  assign battery_cv_sync = status_sync[4];
  assign current_sense_sync = status_sync[5];

  // Flag follows the input only after it holds steady; cleared while detect is off
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      input_overvolt_flag_r <= 1'b0;
      debounce_cnt_r <= 16'h0000;
    end else if (!overvolt_detect_enable_r) begin
      input_overvolt_flag_r <= 1'b0;
      debounce_cnt_r <= 16'h0000;
    end else if (overvolt_sync == input_overvolt_flag_r) begin
      debounce_cnt_r <= 16'h0000;
    end else if (debounce_cnt_r >= 16'(DEBOUNCE_CYC - 1)) begin
      input_overvolt_flag_r <= overvolt_sync; // [R2]
      debounce_cnt_r <= 16'h0000;
    end else begin
      debounce_cnt_r <= debounce_cnt_r + 16'h0001;
    end
  end

  // Serial clock edges; it must run at a quarter of sys_clk or slower
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spi_clk_prev_r <= 1'b0;
    end else begin
      spi_clk_prev_r <= spi_clk;
    end
  end

  assign clk_rise = spi_clk & ~spi_clk_prev_r;
  assign clk_fall = ~spi_clk & spi_clk_prev_r;
  assign write_dir = head_r[`FRAME_ADDR_BITS] == `DIR_WRITE;
  assign frame_addr = head_r[`FRAME_ADDR_BITS-1:0];
  assign wdata_full = {wdata_r[14:0], spi_mosi};
  assign commit_write = (state_r == SPI_DATA) && clk_rise &&
                        (bit_cnt_r == `DATA_LAST_BIT) && write_dir;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SPI_IDLE: begin
        if (!spi_cs_n) begin
          state_nxt = SPI_HEAD;
        end
      end
      SPI_HEAD: begin
        if (spi_cs_n) begin
          state_nxt = SPI_IDLE;
        end else if (clk_rise && bit_cnt_r == `HEAD_LAST_BIT) begin
          state_nxt = SPI_DATA;
        end
      end
      SPI_DATA: begin
        if (spi_cs_n) begin
          state_nxt = SPI_IDLE;
        end else if (clk_rise && bit_cnt_r == `DATA_LAST_BIT) begin
          state_nxt = SPI_DONE;
        end
      end
      SPI_DONE: begin
        if (spi_cs_n) begin
          state_nxt = SPI_IDLE;
        end
      end
      default: state_nxt = SPI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= SPI_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bits are taken msb first on rising serial clock edges
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_r <= 5'd0;
      head_r <= 16'h0000;
      wdata_r <= 16'h0000;
    end else if (spi_cs_n) begin
      bit_cnt_r <= 5'd0;
    end else if (clk_rise && (state_r == SPI_HEAD || state_r == SPI_DATA)) begin
      bit_cnt_r <= bit_cnt_r + 5'd1;
      if (state_r == SPI_HEAD) begin
        head_r <= {head_r[14:0], spi_mosi}; // [R16]
      end else begin
        wdata_r <= {wdata_r[14:0], spi_mosi}; // [R16]
      end
    end
  end

  // Read data is loaded when the header ends and shifted out on falling edges
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_shift_r <= 16'h0000;
      spi_miso_r <= 1'b0;
      spi_miso_oe_r <= 1'b0;
    end else if (spi_cs_n) begin
      spi_miso_r <= 1'b0;
      spi_miso_oe_r <= 1'b0;
    end else if (state_r == SPI_HEAD && clk_rise && bit_cnt_r == `HEAD_LAST_BIT) begin
      rd_shift_r <= read_word(head_r[`FRAME_ADDR_BITS-2:0] == 14'd0 && !spi_mosi ?
                              15'h0000 : {head_r[13:0], spi_mosi});
    end else if (state_r == SPI_DATA && clk_fall && !write_dir) begin
      spi_miso_r <= rd_shift_r[15]; // [R16]
      rd_shift_r <= {rd_shift_r[14:0], 1'b0};
      spi_miso_oe_r <= 1'b1;
    end else if (state_r == SPI_DONE && clk_fall) begin
      spi_miso_oe_r <= 1'b0;
    end
  end

  // Only writable bits take the new word; a short frame writes nothing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      charger_master_enable_r <= 1'(`RST_CTRL_STATUS_0 >> `BIT_MASTER_ENABLE); // [R6]
      sense_dac_enable_r <= 1'(`RST_CTRL_STATUS_0 >> `BIT_SENSE_DAC_ENABLE); // [R6]
      overvolt_detect_enable_r <= 1'(`RST_CTRL_STATUS_0 >> `BIT_OVERVOLT_DETECT_EN); // [R6]
    end else if (commit_write && frame_addr == `ADDR_CTRL_STATUS_0) begin
      charger_master_enable_r <= spi_mosi_word(`BIT_MASTER_ENABLE); // [R1]
      sense_dac_enable_r <= spi_mosi_word(`BIT_SENSE_DAC_ENABLE); // [R4]
      overvolt_detect_enable_r <= spi_mosi_word(`BIT_OVERVOLT_DETECT_EN); // [R17]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      threshold_r <= 4'(`RST_INPUT_THRESHOLD >> `THRESH_LSB); // [R10]
    end else if (commit_write && frame_addr == `ADDR_INPUT_THRESHOLD) begin
      threshold_r <= wdata_full[`THRESH_MSB:`THRESH_LSB];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_compare_enable_r <= 1'(`RST_BATTERY_SENSE >> `BIT_CS_COMPARE_EN); // [R15]
    end else if (commit_write && frame_addr == `ADDR_BATTERY_SENSE) begin
      cs_compare_enable_r <= spi_mosi_word(`BIT_CS_COMPARE_EN); // [R14]
    end
  end

  // Full data word including the bit arriving on the final edge
  function automatic reg_word_t last_word();
    last_word = wdata_full;
  endfunction

  function automatic logic spi_mosi_word(input int pos);
    reg_word_t w;
    w = last_word();
    spi_mosi_word = w[pos];
  endfunction

  // Charging outputs; master enable gates every charge path
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gated_dac_enable_r <= 1'b0;
      auto_charge_enable_r <= 1'b0;
      hw_cv_enable_r <= 1'b0;
      pulse_charge_enable_r <= 1'b0;
    end else begin
      gated_dac_enable_r <= charger_master_enable_r & sense_dac_enable_r; // [R1] [R4]
      auto_charge_enable_r <= charger_master_enable_r; // [R1]
      hw_cv_enable_r <= charger_master_enable_r; // [R1]
      pulse_charge_enable_r <= charger_master_enable_r & regulator_ok_sync; // [R5]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      threshold_mv_r <= `THRESH_RESET_MV; // [R10]
    end else begin
      threshold_mv_r <= threshold_to_mv(threshold_r); // [R7] [R8] [R9]
    end
  end

  assign spi_miso = spi_miso_r;
  assign spi_miso_oe = spi_miso_oe_r;
  assign gated_dac_enable = gated_dac_enable_r;
  assign auto_charge_enable = auto_charge_enable_r;
  assign hardware_const_voltage_enable = hw_cv_enable_r;
  assign pulse_charge_enable = pulse_charge_enable_r;
  assign input_overvolt_detect_enable = overvolt_detect_enable_r;
  assign input_overvolt_threshold = threshold_r;
  assign overvolt_threshold_mv = threshold_mv_r;
  assign current_sense_compare_enable = cs_compare_enable_r;

endmodule

// ==== hw/charger_regs_defines.svh ====
`ifndef CHARGER_REGS_DEFINES_SVH
`define CHARGER_REGS_DEFINES_SVH

// Register byte addresses on the serial port
`define ADDR_CTRL_STATUS_0 15'h0000
`define ADDR_INPUT_THRESHOLD 15'h0002
`define ADDR_BATTERY_SENSE 15'h0004

// Reset values
`define RST_CTRL_STATUS_0 16'h0001
`define RST_INPUT_THRESHOLD 16'h00f2
`define RST_BATTERY_SENSE 16'h0004

// Writable bit masks
`define WMASK_CTRL_STATUS_0 16'h0019
`define WMASK_INPUT_THRESHOLD 16'h00f0
`define WMASK_BATTERY_SENSE 16'h0008

// Read-only bits that hold their reset value
`define FIXED_INPUT_THRESHOLD 16'h0002
`define FIXED_BATTERY_SENSE 16'h0004

// Control word 0 fields
`define BIT_OVERVOLT_FLAG 7
`define BIT_CHARGER_PRESENT 5
`define BIT_MASTER_ENABLE 4
`define BIT_SENSE_DAC_ENABLE 3
`define BIT_REGULATOR_OK 1
`define BIT_OVERVOLT_DETECT_EN 0

// Control word 1 field
`define THRESH_MSB 7
`define THRESH_LSB 4

// Control word 2 fields
`define BIT_BATTERY_CC 7
`define BIT_BATTERY_CV 6
`define BIT_CURRENT_SENSE 5
`define BIT_CS_COMPARE_EN 3

// Serial frame layout
`define FRAME_DIR_BITS 1
`define FRAME_ADDR_BITS 15
`define FRAME_DATA_BITS 16
`define HEAD_LAST_BIT 5'd15
`define DATA_LAST_BIT 5'd31
`define DIR_WRITE 1'b1

// Threshold ranges, in millivolts
`define THRESH_LOW_LAST 4'h8
`define THRESH_MID_LAST 4'hc
`define THRESH_MID_FIRST 4'h9
`define THRESH_HIGH_FIRST 4'hd
`define THRESH_LOW_BASE_MV 14'd4200
`define THRESH_MID_BASE_MV 14'd6000
`define THRESH_HIGH_BASE_MV 14'd8500
`define THRESH_LOW_STEP_MV 14'd50
`define THRESH_MID_STEP_MV 14'd500
`define THRESH_HIGH_STEP_MV 14'd1000
`define THRESH_RESET_MV 14'd10500

// Timing
`define SYS_CLK_HZ 10000000
`define OVERVOLT_DEBOUNCE_NS 1000
`define OVERVOLT_DEBOUNCE_CYC ((`OVERVOLT_DEBOUNCE_NS * (`SYS_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ==== hw/charger_regs_pkg.sv ====
package charger_regs_pkg;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_HEAD = 2'b01,
    SPI_DATA = 2'b11,
    SPI_DONE = 2'b10
  } spi_state_t;
  typedef logic [15:0] reg_word_t;
  typedef logic [13:0] millivolt_t;
endpackage

// ==== hw/status_sync.sv ====
`timescale 1ns/100ps
module status_sync #(
  parameter int WIDTH = 5
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Raw comparator levels
  output logic [WIDTH-1:0] sync_out // Levels in the clock domain
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;
endmodule
